// file: design/rot_pkg.sv
package rot_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int POR_MIN_NS = 100_000_000;
  localparam int POR_MIN_CYC = (POR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HALT_NS = 1_000_000;
  localparam int HALT_CYC = HALT_NS / CLK_PERIOD_NS;
  localparam int OSC_START_EDGES = 1024;

  // time count chain
  localparam int TICKS_PER_SEC = 32768;
  localparam int TICKS_PER_UNIT = 2;
  localparam int TRIM_FULL_SCALE = 128;
  localparam int SHORT_INTERVAL = 20;
  localparam int LONG_INTERVAL = 60;
  localparam int TICK_W = 17;

  // register map
  localparam logic [3:0] ADDR_SECONDS = 4'h0;
  localparam logic [3:0] ADDR_TRIM = 4'h7;
  localparam logic [3:0] ADDR_CTRL1 = 4'hE;
  localparam logic [3:0] ADDR_CTRL2 = 4'hF;

  // field positions
  localparam int CTRL1_ECO_BIT = 3;
  localparam int CTRL2_PON_BIT = 4;
  localparam int CTRL2_HALT_BIT = 5;

  // reset values and read fill values
  localparam logic [7:0] TRIM_RST = 8'h00;
  localparam logic CTRL1_ECO_RST = 1'b0;
  localparam logic PON_RST = 1'b1;
  localparam logic HALT_RST = 1'b0;
  localparam logic [7:0] SECONDS_RST = 8'h00;
  localparam logic [7:0] BLOCKED_READ = 8'hFF;
  localparam logic [7:0] IDLE_READ = 8'h00;

  typedef struct packed {
    logic interval_sel;
    logic [6:0] value;
  } rot_trim_t;

  typedef struct packed {
    logic power_on;
    logic osc_halt;
  } rot_flags_t;

  typedef enum logic {
    ROT_BLOCKED = 1'b0,
    ROT_OPEN = 1'b1
  } rot_por_state_t;

endpackage

// file: design/rot_por.sv
`timescale 1ns/100ps
module rot_por
  import rot_pkg::*;
#(
  parameter int MIN_CYC = POR_MIN_CYC,
  parameter int START_EDGES = OSC_START_EDGES
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic osc_edge,
  output logic blocked
);

  rot_por_state_t state_reg, state_next;
  logic [31:0] time_reg, time_next;
  logic [15:0] edges_reg, edges_next;

  // hold bus off until the crystal runs and the least start time passed
  always_comb begin
    state_next = state_reg;
    time_next = time_reg;
    edges_next = edges_reg;
    unique case (state_reg)
      ROT_BLOCKED: begin
        if (time_reg < 32'(MIN_CYC)) begin
          time_next = time_reg + 32'd1;
        end
        if (osc_edge && edges_reg < 16'(START_EDGES)) begin
          edges_next = edges_reg + 16'd1;
        end
        if (time_reg >= 32'(MIN_CYC) && edges_reg >= 16'(START_EDGES)) begin
          state_next = ROT_OPEN;
        end
      end
      ROT_OPEN: begin
        state_next = ROT_OPEN;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ROT_BLOCKED;
      time_reg <= 32'h0000_0000;
      edges_reg <= 16'h0000;
      blocked <= 1'b1;
    end else begin
      state_reg <= state_next;
      time_reg <= time_next;
      edges_reg <= edges_next;
      blocked <= (state_next == ROT_BLOCKED);
    end
  end

endmodule

// file: design/rot_trim.sv
`timescale 1ns/100ps
module rot_trim
  import rot_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic tick,
  input rot_trim_t trim,
  output logic sec_pulse
);

  logic [TICK_W-1:0] tick_reg, tick_next;
  logic [TICK_W-1:0] period_reg, period_next;
  logic [5:0] interval_reg, interval_next;
  logic sec_next;

  // count crystal ticks; the trimmed second opens each interval after the first, which follows reset untrimmed
  always_comb begin
    int adj;
    int limit;
    adj = 0;
    limit = trim.interval_sel ? LONG_INTERVAL : SHORT_INTERVAL;
    tick_next = tick_reg;
    period_next = period_reg;
    interval_next = interval_reg;
    sec_next = 1'b0;
    if (trim.value == 7'h00) begin
      adj = 0;
    end else if (!trim.value[6]) begin
      adj = (int'(trim.value) - 1) * TICKS_PER_UNIT;
    end else begin
      adj = -((TRIM_FULL_SCALE - int'(trim.value)) * TICKS_PER_UNIT);
    end
    if (tick) begin
      if (tick_reg >= period_reg - 17'd1) begin
        tick_next = '0;
        sec_next = 1'b1;
        if (int'(interval_reg) >= limit - 1) begin
          interval_next = 6'h00;
          period_next = TICK_W'(TICKS_PER_SEC + adj);
        end else begin
          interval_next = interval_reg + 6'h01;
          period_next = TICK_W'(TICKS_PER_SEC);
        end
      end else begin
        tick_next = tick_reg + 17'd1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tick_reg <= '0;
      period_reg <= TICK_W'(TICKS_PER_SEC);
      interval_reg <= 6'h00;
      sec_pulse <= 1'b0;
    end else begin
      tick_reg <= tick_next;
      period_reg <= period_next;
      interval_reg <= interval_next;
      sec_pulse <= sec_next;
    end
  end

endmodule

// file: design/rot_top.sv
`timescale 1ns/100ps
module rot_top
  import rot_pkg::*;
#(
  parameter bit PIN_VARIANT = 1'b0,
  parameter int POR_CYC = POR_MIN_CYC,
  parameter int HALT_DET_CYC = HALT_CYC,
  parameter int START_EDGES = OSC_START_EDGES
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic xtal_in,
  input wire logic low_power_sel_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  output logic sub_clock_out,
  output logic osc_eco_mode,
  output logic osc_boost,
  output logic bus_blocked,
  output logic sec_pulse
);

  logic xtal_d_reg;
  logic osc_edge;
  logic blocked;
  logic sec_tick;
  logic [31:0] halt_cnt_reg, halt_cnt_next;
  rot_flags_t flags_reg, flags_next;
  logic low_power_osc_select_reg, low_power_osc_select_next;
  rot_trim_t trim_reg, trim_next;
  logic [7:0] seconds_reg, seconds_next;
  logic [7:0] rd_data_next;
  logic eco_next;
  logic boost_next;
  logic halt_seen;
  logic wr_ok;
  logic rd_ok;

  // rising crystal edge, input is already synchronous
  assign osc_edge = xtal_in & ~xtal_d_reg;
  assign halt_seen = (halt_cnt_reg >= 32'(HALT_DET_CYC));
  assign wr_ok = wr_en & ~blocked;
  assign rd_ok = rd_en & ~blocked;

  rot_por #(
    .MIN_CYC(POR_CYC),
    .START_EDGES(START_EDGES)
  ) u_por (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .osc_edge(osc_edge),
    .blocked(blocked)
  );

  rot_trim u_trim (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .tick(osc_edge),
    .trim(trim_reg),
    .sec_pulse(sec_tick)
  );

  // oscillator watchdog: no edge for the halt time raises the flag
  always_comb begin
    halt_cnt_next = halt_cnt_reg;
    if (osc_edge) begin
      halt_cnt_next = 32'h0000_0000;
    end else if (!halt_seen) begin
      halt_cnt_next = halt_cnt_reg + 32'd1;
    end
  end

  // register writes; hardware set beats a clearing write
  always_comb begin
    flags_next = flags_reg;
    low_power_osc_select_next = low_power_osc_select_reg;
    trim_next = trim_reg;
    if (wr_ok) begin
      unique case (addr)
        ADDR_CTRL1: begin
          low_power_osc_select_next = wr_data[CTRL1_ECO_BIT];
        end
        ADDR_CTRL2: begin
          // flags only accept a zero
          if (!wr_data[CTRL2_PON_BIT]) begin
            flags_next.power_on = 1'b0;
          end
          if (!wr_data[CTRL2_HALT_BIT]) begin
            flags_next.osc_halt = 1'b0;
          end
        end
        ADDR_TRIM: begin
          trim_next = wr_data;
        end
        default: begin
          trim_next = trim_reg;
        end
      endcase
    end
    if (halt_seen) begin
      flags_next.osc_halt = 1'b1;
    end
  end

  // seconds count seen by software, advanced by the trimmed chain
  always_comb begin
    seconds_next = seconds_reg;
    if (sec_tick) begin
      seconds_next = seconds_reg + 8'h01;
    end
  end

  // read data stands only in the cycle after the strobe
  always_comb begin
    rd_data_next = IDLE_READ;
    if (rd_en && blocked) begin
      rd_data_next = BLOCKED_READ;
    end else if (rd_ok) begin
      unique case (addr)
        ADDR_SECONDS: begin
          rd_data_next = seconds_reg;
        end
        ADDR_CTRL1: begin
          rd_data_next = 8'(low_power_osc_select_reg) << CTRL1_ECO_BIT;
        end
        ADDR_CTRL2: begin
          rd_data_next = (8'(flags_reg.power_on) << CTRL2_PON_BIT)
                       | (8'(flags_reg.osc_halt) << CTRL2_HALT_BIT);
        end
        ADDR_TRIM: begin
          rd_data_next = trim_reg;
        end
        default: begin
          rd_data_next = IDLE_READ;
        end
      endcase
    end
  end

  // oscillator mode outputs
  always_comb begin
    if (PIN_VARIANT) begin
      eco_next = ~low_power_sel_n;
    end else begin
      eco_next = low_power_osc_select_reg;
    end
    boost_next = flags_reg.power_on | flags_reg.osc_halt;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      xtal_d_reg <= 1'b0;
      halt_cnt_reg <= 32'h0000_0000;
      flags_reg.power_on <= PON_RST;
      flags_reg.osc_halt <= HALT_RST;
      low_power_osc_select_reg <= CTRL1_ECO_RST;
      trim_reg <= TRIM_RST;
      seconds_reg <= SECONDS_RST;
      rd_data <= IDLE_READ;
      sub_clock_out <= 1'b0;
      osc_eco_mode <= 1'b0;
      osc_boost <= 1'b1;
      bus_blocked <= 1'b1;
      sec_pulse <= 1'b0;
    end else begin
      xtal_d_reg <= xtal_in;
      halt_cnt_reg <= halt_cnt_next;
      flags_reg <= flags_next;
      low_power_osc_select_reg <= low_power_osc_select_next;
      trim_reg <= trim_next;
      seconds_reg <= seconds_next;
      rd_data <= rd_data_next;
      sub_clock_out <= xtal_in;
      osc_eco_mode <= eco_next;
      osc_boost <= boost_next;
      bus_blocked <= blocked;
      sec_pulse <= sec_tick;
    end
  end

endmodule

// file: testbench/rot_xtal_model.sv
`timescale 1ns/100ps
module rot_xtal_model (
  input wire logic ref_clk,
  input wire logic run,
  output logic xtal_in
);
  initial xtal_in = 1'b0;
  // crystal swings every cycle while running, a stopped crystal rests low
  always @(posedge ref_clk) begin
    xtal_in <= run ? !xtal_in : 1'b0;
  end
endmodule

// file: testbench/rot_chk.sv
`timescale 1ns/100ps
module rot_chk
  import rot_pkg::*;
#(
  parameter int HALT_DET_CYC = HALT_CYC
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic xtal_in,
  input wire logic low_power_sel_n,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rd_data,
  input wire logic sub_clock_out,
  input wire logic osc_eco_mode,
  input wire logic osc_boost,
  input wire logic bus_blocked,
  input wire logic sec_pulse
);
  logic xq_reg;
  logic [7:0] still_reg;
  logic [7:0] still_next;
  // cycles since the crystal line last moved, saturating
  always_comb begin
    still_next = (xtal_in != xq_reg) ? 8'h00 : still_reg + 8'(still_reg != 8'hFF);
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      xq_reg <= 1'b0;
      still_reg <= 8'h00;
    end else begin
      xq_reg <= xtal_in;
      still_reg <= still_next;
    end
  end
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  AST_SUB_CLK: assert property (sub_clock_out == $past(xtal_in))
    else $error("sub clock is not the crystal copy");
  AST_BLK_RD: assert property ($past(rd_en) && $past(bus_blocked) && bus_blocked |-> rd_data == 8'hFF)
    else $error("blocked read not FFh");
  AST_BLK_STAY: assert property (!bus_blocked |=> !bus_blocked)
    else $error("bus blocked again");
  AST_PULSE: assert property (sec_pulse |=> !sec_pulse)
    else $error("second pulse too long");
  AST_PULSE_TICK: assert property (sec_pulse |-> $past(xtal_in, 2) && !$past(xtal_in, 3))
    else $error("second pulse off tick");
  AST_BOOST_HALT: assert property (still_reg == HALT_DET_CYC + 6 |-> osc_boost)
    else $error("no boost on halted crystal");
  AST_BOOST_FALL: assert property ($fell(osc_boost) |-> $past(wr_en) || $past(wr_en, 2))
    else $error("boost ended without flag clear");
  AST_ECO_QUIET: assert property (!$past(wr_en) && !$past(wr_en, 2)
    && $past(low_power_sel_n) == $past(low_power_sel_n, 2) |-> $stable(osc_eco_mode))
    else $error("eco mode moved without write");
endmodule
bind rot_top rot_chk #(.HALT_DET_CYC(HALT_DET_CYC)) chk_u (.ref_clk(ref_clk), .resetn(resetn),
  .xtal_in(xtal_in), .low_power_sel_n(low_power_sel_n), .wr_en(wr_en), .rd_en(rd_en),
  .rd_data(rd_data),
  .sub_clock_out(sub_clock_out), .osc_eco_mode(osc_eco_mode), .osc_boost(osc_boost),
  .bus_blocked(bus_blocked), .sec_pulse(sec_pulse));

// file: testbench/tb.sv
`timescale 1ns/100ps
module tb;
  import rot_pkg::*;
  logic ref_clk = 0, resetn = 0, run = 0, low_power_sel_n = 1, wr_en = 0, rd_en = 0;
  logic [3:0] addr = 0;
  logic [7:0] wr_data = 0, rd_data, v;
  logic xtal_in, sub_clock_out, osc_eco_mode, osc_boost, bus_blocked, sec_pulse, xq = 0;
  logic eco_p;
  int failures = 0, n_checks = 0, seed = 16496, cyc = 0, ticks = 0, t_tick = 0;
  int mdl [16] = '{15: 8'h10, default: 0};
  // free running reference clock
  always #5 ref_clk = !ref_clk;
  rot_xtal_model xm_u (.ref_clk(ref_clk), .run(run), .xtal_in(xtal_in));
  rot_top #(.POR_CYC(20), .HALT_DET_CYC(50), .START_EDGES(4)) dut_u (.ref_clk(ref_clk),
    .resetn(resetn), .xtal_in(xtal_in), .low_power_sel_n(low_power_sel_n), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .sub_clock_out(sub_clock_out), .osc_eco_mode(osc_eco_mode), .osc_boost(osc_boost),
    .bus_blocked(bus_blocked), .sec_pulse(sec_pulse));
  // pin-controlled variant beside the register one
  rot_top #(.PIN_VARIANT(1'b1), .POR_CYC(20), .HALT_DET_CYC(50), .START_EDGES(4)) dut_p (
    .ref_clk(ref_clk), .resetn(resetn), .xtal_in(xtal_in), .low_power_sel_n(low_power_sel_n),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(),
    .sub_clock_out(), .osc_eco_mode(eco_p), .osc_boost(), .bus_blocked(), .sec_pulse());
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    if (bus_blocked === 1'b0 && (a == ADDR_TRIM || a == ADDR_CTRL1)) mdl[a] = d;
    if (bus_blocked === 1'b0 && a == ADDR_CTRL2) mdl[a] = mdl[a] & d;
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk) wr_en <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk) rd_en <= 1'b0;
    @(negedge ref_clk) chk(rd_data, exp);
    @(posedge ref_clk);
  endtask
  task automatic wait3();
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // reference tick counter, marks the closing tick of the first second
  always @(posedge ref_clk) begin
    cyc++;
    if (resetn && xtal_in && !xq) ticks++;
    if (ticks == TICKS_PER_SEC && t_tick == 0) t_tick = cyc;
    xq = xtal_in;
  end
  // each second pulse is timed against the reference count
  always @(negedge ref_clk) begin
    if (sec_pulse === 1'b1) begin
      chk(8'(cyc - t_tick), 8'h01);
      mdl[0]++;
    end
  end
  // main sequence
  initial begin
    repeat (20) @(posedge ref_clk);
    chk1(osc_boost, 1'b1);
    chk1(bus_blocked, 1'b1);
    resetn <= 1'b1;
    run <= 1'b1;
    @(posedge ref_clk);
    rd(ADDR_TRIM, 8'hFF);
    wr(ADDR_TRIM, 8'h55);
    for (int i = 0; i < 500 && bus_blocked !== 1'b0; i++) @(posedge ref_clk);
    chk1(bus_blocked, 1'b0);
    rd(ADDR_TRIM, 8'(mdl[7]));
    rd(ADDR_CTRL1, 8'h00);
    rd(ADDR_CTRL2, 8'h10);
    $display("reset and bus blocking done");
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      v[7] = i[0];
      wr(ADDR_TRIM, v);
      rd(ADDR_TRIM, 8'(mdl[7]));
    end
    wr(ADDR_TRIM, 8'h81);
    $display("trim register done");
    low_power_sel_n <= 1'b0;
    wr(ADDR_CTRL1, 8'h08);
    wait3();
    chk1(osc_eco_mode, 1'b1);
    chk1(eco_p, 1'b1);
    low_power_sel_n <= 1'b1;
    wr(ADDR_CTRL1, 8'h00);
    wait3();
    chk1(osc_eco_mode, 1'b0);
    chk1(eco_p, 1'b0);
    wr(ADDR_CTRL2, 8'h00);
    wait3();
    chk1(osc_boost, 1'b0);
    rd(ADDR_CTRL2, 8'(mdl[15]));
    $display("oscillator modes done");
    run <= 1'b0;
    repeat (80) @(posedge ref_clk);
    chk1(osc_boost, 1'b1);
    mdl[15] = 8'h20;
    rd(ADDR_CTRL2, 8'(mdl[15]));
    run <= 1'b1;
    repeat (8) @(posedge ref_clk);
    wr(ADDR_CTRL2, 8'h00);
    wait3();
    chk1(osc_boost, 1'b0);
    rd(4'h3, 8'h00);
    $display("halt and boost done");
    for (int i = 0; i < 70000 && mdl[0] == 0; i++) @(posedge ref_clk);
    wait3();
    chk1(1'(mdl[0] > 0), 1'b1);
    rd(ADDR_SECONDS, 8'(mdl[0]));
    $display("second count done");
    wrap_up();
  end
  // watchdog against a hang
  initial begin
    #1_000_000;
    failures++;
    $display("ERROR %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule
